// ===== verilog/sbsa_top.sv
`include "sbsa_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sbsa_top
	import sbsa_pkg::*;
#(
	parameter int DATA_W  = `SBSA_DATA_W,
	parameter int ADDR_W  = `SBSA_ADDR_W,
	parameter int F_DEPTH = `SBSA_FIFO_DEPTH
) (
	input  wire logic              SYS_CLK,
	input  wire logic              RESETN,
	input  wire logic [ADDR_W-1:0] ADDR,
	input  wire logic [DATA_W-1:0] DQ_IN,
	output logic      [DATA_W-1:0] DQ_OUT,
	output logic                   DQ_OE,
	input  wire logic              PROCESSOR_ADDR_STROBE_N,
	input  wire logic              CONTROLLER_ADDR_STROBE_N,
	input  wire logic              BURST_ADVANCE_N,
	input  wire logic              PRIMARY_CHIP_SELECT_N,
	input  wire logic              DEPTH_SELECT_HIGH,
	input  wire logic              DEPTH_SELECT_LOW_N,
	input  wire logic [3:0]        BYTE_LANE_WRITE_ENABLES_N,
	input  wire logic              BYTE_WRITE_MASTER_ENABLE_N,
	input  wire logic              ALL_BYTES_WRITE_N,
	input  wire logic              OUTPUT_ENABLE_N,
	input  wire logic              SLEEP_REQUEST,
	output logic      [DATA_W-1:0] RD_DATA,
	output logic                   RD_VALID,
	input  wire logic              RD_READY,
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [11:0]       PADDR,
	input  wire logic [31:0]       PWDATA,
	output logic      [31:0]       PRDATA,
	output logic                   PREADY,
	output logic                   PSLVERR
);
	localparam int DEPTH = 1 << ADDR_W;
	localparam int LANE  = DATA_W / 4;
	initial if ((DATA_W != 36 || ADDR_W != 19) && (DATA_W != 18 || ADDR_W != 20))
		$error("Only 512K x 36 or 1M x 18 organisations are supported");

	logic [DATA_W-1:0] mem_q [DEPTH];
	logic [ADDR_W-1:0] addr_q;
	logic              sel_q;
	logic              wr_q;
	logic [3:0]        lanes_q;
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] wdata_q;
	logic [31:0]       ctrl_q;
	logic [15:0]       count_q;
	logic [31:0]       prdata_q;
	logic [1:0]        beat_q;
	logic [1:0]        low_addr;
	logic              adv_q;
	logic              fresh_q;
	wire  [DATA_W-1:0] wr_word;
	sbsa_state_t       state_q;
	sbsa_state_t       state_d;

	wire strobe  = !PROCESSOR_ADDR_STROBE_N || !CONTROLLER_ADDR_STROBE_N;
	wire sel_now = !PRIMARY_CHIP_SELECT_N && DEPTH_SELECT_HIGH && !DEPTH_SELECT_LOW_N;
	wire advance = !strobe && !BURST_ADVANCE_N && sel_q;
	wire enabled = ctrl_q[`SBSA_CTRL_ENA];
	wire asleep  = SLEEP_REQUEST || ctrl_q[`SBSA_CTRL_SLEEP];
	wire fifo_in_ready;
	wire wr_any  = !ALL_BYTES_WRITE_N || !BYTE_WRITE_MASTER_ENABLE_N;
	wire [3:0] lane_en = !ALL_BYTES_WRITE_N ? 4'hF :
		(!BYTE_WRITE_MASTER_ENABLE_N ? ~BYTE_LANE_WRITE_ENABLES_N : 4'h0);
	wire [ADDR_W-1:0] cur_addr = {addr_q[ADDR_W-1:2], low_addr};

	sbsa_burst_ctr u_ctr (
		.clk        (SYS_CLK),
		.rst_n      (RESETN),
		.load       (strobe),
		.start      (ADDR[1:0]),
		.advance    (advance),
		.interleave (ctrl_q[`SBSA_CTRL_MODE]),
		.low_addr   (low_addr)
	);

	// Address and selects change only on a strobe edge
	always_ff @(posedge SYS_CLK)
	begin
		if (!RESETN)
		begin
			addr_q <= '0;
			sel_q  <= 1'b0;
		end
		else if (strobe)
		begin
			addr_q <= ADDR;
			sel_q  <= sel_now && enabled && !asleep;
		end
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (!RESETN)
		begin
			wr_q    <= 1'b0;
			lanes_q <= 4'h0;
			wdata_q <= '0;
		end
		else
		begin
			wr_q    <= wr_any && sel_q && !asleep && !strobe;
			lanes_q <= lane_en;
			wdata_q <= DQ_IN;
		end
	end

	// Merge enabled lanes into the stored word so the array has one writer
	for (genvar g = 0; g < 4; g++)
	begin : g_lane
		assign wr_word[g*LANE +: LANE] = lanes_q[g] ? wdata_q[g*LANE +: LANE]
			: mem_q[cur_addr][g*LANE +: LANE];
	end
	if (DATA_W > 4 * LANE)
	begin : g_rest
		assign wr_word[DATA_W-1:4*LANE] = mem_q[cur_addr][DATA_W-1:4*LANE];
	end

	// Write lands one edge after data is captured
	always_ff @(posedge SYS_CLK)
	begin
		if (wr_q)
			mem_q[cur_addr] <= wr_word;
	end

	// Burst timing: first beat after two edges, then one per edge
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			SBSA_IDLE:  if (strobe && sel_now) state_d = SBSA_FIRST;
			SBSA_FIRST: state_d = strobe ? (sel_now ? SBSA_FIRST : SBSA_IDLE) : SBSA_BEAT;
			SBSA_BEAT:  if (strobe) state_d = sel_now ? SBSA_FIRST : SBSA_IDLE;
			default:    state_d = SBSA_IDLE;
		endcase
	end
	always_ff @(posedge SYS_CLK)
	begin
		if (!RESETN)
			state_q <= SBSA_IDLE;
		else
			state_q <= state_d;
	end
	always_ff @(posedge SYS_CLK)
	begin
		if (!RESETN)
			beat_q <= 2'h0;
		else if (strobe)
			beat_q <= 2'h0;
		else if (advance)
			beat_q <= beat_q + 2'h1;
	end

	// Read data registered once per edge
	always_ff @(posedge SYS_CLK)
	begin
		if (!RESETN)
			rdata_q <= '0;
		else
			rdata_q <= mem_q[cur_addr];
	end
	// Read data is new one edge after the first address or after each advance
	always_ff @(posedge SYS_CLK)
	begin
		if (!RESETN)
		begin
			adv_q   <= 1'b0;
			fresh_q <= 1'b0;
		end
		else
		begin
			adv_q   <= advance;
			fresh_q <= sel_q && !wr_any && !strobe && ((state_q == SBSA_FIRST) || adv_q);
		end
	end
	wire rd_push = fresh_q && !wr_q && !asleep && fifo_in_ready;

	always_ff @(posedge SYS_CLK)
	begin
		if (!RESETN)
			count_q <= 16'h0000;
		else if (rd_push)
			count_q <= count_q + 16'h0001;
	end

	sbsa_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (F_DEPTH)
	) u_fifo (
		.clk       (SYS_CLK),
		.rst_n     (RESETN),
		.in_data   (rdata_q),
		.in_valid  (rd_push),
		.in_ready  (fifo_in_ready),
		.out_data  (RD_DATA),
		.out_valid (RD_VALID),
		.out_ready (RD_READY)
	);

	assign DQ_OUT = rdata_q;
	// Output drive is gated without the clock
	assign DQ_OE = !OUTPUT_ENABLE_N && !SLEEP_REQUEST && sel_q && !wr_q;

	// APB slave, zero wait states
	wire apb_wr = PSEL && PENABLE && PWRITE;
	wire hit    = (PADDR == `SBSA_REG_CTRL) || (PADDR == `SBSA_REG_STAT)
		|| (PADDR == `SBSA_REG_COUNT);
	always_ff @(posedge SYS_CLK)
	begin
		if (!RESETN)
			ctrl_q <= `SBSA_CTRL_RST;
		else if (apb_wr && PADDR == `SBSA_REG_CTRL)
			ctrl_q <= {29'h0, PWDATA[2:0]};
	end
	always_comb
	begin
		prdata_q = 32'h00000000;
		case (PADDR)
			`SBSA_REG_CTRL:  prdata_q = ctrl_q;
			`SBSA_REG_STAT:  prdata_q = {25'h0, fifo_in_ready, RD_VALID, beat_q, state_q, sel_q};
			`SBSA_REG_COUNT: prdata_q = {16'h0000, count_q};
			default:         prdata_q = 32'h00000000;
		endcase
	end
	assign PRDATA  = prdata_q;
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !hit;

	chk_strobe_load: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		strobe |=> addr_q == $past(ADDR)) else $error("address not loaded on strobe");
	chk_hold_addr: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		!strobe |=> $stable(addr_q)) else $error("address changed without strobe");
	chk_upper_fixed: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		advance |=> cur_addr[ADDR_W-1:2] == $past(cur_addr[ADDR_W-1:2]))
		else $error("upper address moved in burst");
	chk_linear_step: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		advance && !ctrl_q[`SBSA_CTRL_MODE] && $stable(ctrl_q) |=>
		low_addr == $past(low_addr) + 2'h1) else $error("linear step wrong");
	chk_first_two: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		state_q == SBSA_IDLE && strobe && sel_now |=> state_q == SBSA_FIRST ##1
		state_q == SBSA_BEAT) else $error("first beat not two cycles");
	chk_select_all: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		strobe && !sel_now |=> !sel_q) else $error("selected with inactive select");
	chk_either_strobe: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		!CONTROLLER_ADDR_STROBE_N && PROCESSOR_ADDR_STROBE_N |=> beat_q == 2'h0)
		else $error("controller strobe did not start burst");
	chk_oe_async: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		OUTPUT_ENABLE_N |-> !DQ_OE) else $error("drive while output enable off");
	chk_adv_count: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		advance |=> beat_q == $past(beat_q) + 2'h1) else $error("advance not counted");
endmodule // sbsa_top
`default_nettype wire

// ===== verilog/sbsa_cfg.svh
`ifndef SBSA_CFG_SVH
`define SBSA_CFG_SVH
`define SBSA_DATA_W      36
`define SBSA_ADDR_W      19
`define SBSA_FIFO_DEPTH  32
`define SBSA_BURST_LEN   4
`define SBSA_REG_CTRL    12'h000
`define SBSA_REG_STAT    12'h004
`define SBSA_REG_COUNT   12'h008
`define SBSA_CTRL_RST    32'h00000001
`define SBSA_CTRL_ENA    0
`define SBSA_CTRL_MODE   1
`define SBSA_CTRL_SLEEP  2
`endif

// ===== verilog/sbsa_pkg.sv
package sbsa_pkg;
	typedef enum logic [1:0]
	{
		SBSA_IDLE  = 2'b00,
		SBSA_FIRST = 2'b01,
		SBSA_BEAT  = 2'b10
	} sbsa_state_t;
endpackage

// ===== verilog/sbsa_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module sbsa_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	initial if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wr_q;
	logic [AW:0]      rd_q;
	wire              do_wr = in_valid && in_ready;
	wire              do_rd = out_valid && out_ready;
	assign in_ready  = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
	assign out_valid = wr_q != rd_q;
	assign out_data  = mem_q[rd_q[AW-1:0]];
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			wr_q <= '0;
		else if (do_wr)
			wr_q <= wr_q + 1'b1;
	end
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			rd_q <= '0;
		else if (do_rd)
			rd_q <= rd_q + 1'b1;
	end
	always_ff @(posedge clk)
	begin
		if (do_wr)
			mem_q[wr_q[AW-1:0]] <= in_data;
	end
endmodule // sbsa_fifo
`default_nettype wire

// ===== verilog/sbsa_burst_ctr.sv
`timescale 1ns/1ps
`default_nettype none
module sbsa_burst_ctr (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       load,
	input  wire logic [1:0] start,
	input  wire logic       advance,
	input  wire logic       interleave,
	output logic      [1:0] low_addr
);
	logic [1:0] base_q;
	logic [1:0] cnt_q;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			cnt_q <= 2'h0;
		else if (load)
			cnt_q <= 2'h0;
		else if (advance)
			cnt_q <= cnt_q + 2'h1;
	end
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			base_q <= 2'h0;
		else if (load)
			base_q <= start;
	end
	// Interleaved order xors the count, linear adds it and wraps in four words
	assign low_addr = interleave ? (base_q ^ cnt_q) : (base_q + cnt_q);
endmodule // sbsa_burst_ctr
`default_nettype wire

// ===== dv/sbsa_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module sbsa_cpu_model #(
	parameter int AW = 19
) (
	input  wire logic          clk,
	output logic      [AW-1:0] addr,
	output logic               pstb_n,
	output logic               cstb_n,
	output logic               adv_n,
	output logic               sel_n,
	output logic               gw_n
);
	initial
	begin
		{pstb_n, cstb_n, adv_n, sel_n, gw_n} = 5'h1F;
		addr = '0;
	end
	// One strobe cycle, then the bus shows the inverse address
	task automatic start(input logic [AW-1:0] a, input logic c, input logic s);
		@(posedge clk);
		addr <= a;
		pstb_n <= c;
		cstb_n <= !c;
		sel_n <= !s;
		@(posedge clk);
		{pstb_n, cstb_n, sel_n} <= 3'h7;
		addr <= ~a;
	endtask
	task automatic burst();
		@(posedge clk);
		adv_n <= 1'b0;
		repeat (3) @(posedge clk);
		adv_n <= 1'b1;
	endtask
	task automatic write1();
		gw_n <= 1'b0;
		@(posedge clk);
		gw_n <= 1'b1;
	endtask
endmodule // sbsa_cpu_model
`default_nettype wire

// ===== dv/tb_sbsa_top.sv
`include "sbsa_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_sbsa_top;
	logic        SYS_CLK, RESETN, RD_READY, PSEL, PENABLE, PWRITE;
	logic        OUTPUT_ENABLE_N, SLEEP_REQUEST, DQ_OE, RD_VALID, PREADY, PSLVERR;
	logic        ps_n, cs_n, adv_n, sel_n, gw_n;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA;
	logic [35:0] dq_in, RD_DATA, mem [4];
	logic [35:0] exp_q [$];
	logic [18:0] a_w;
	int          n_mismatch = 0;
	int          check_count = 0;
	sbsa_cpu_model cpu (.clk(SYS_CLK), .addr(a_w), .pstb_n(ps_n), .cstb_n(cs_n),
		.adv_n(adv_n), .sel_n(sel_n), .gw_n(gw_n));
	sbsa_top sbsa_top_inst (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .ADDR(a_w), .DQ_IN(dq_in),
		.DQ_OUT(), .DQ_OE(DQ_OE), .PROCESSOR_ADDR_STROBE_N(ps_n),
		.CONTROLLER_ADDR_STROBE_N(cs_n), .BURST_ADVANCE_N(adv_n),
		.PRIMARY_CHIP_SELECT_N(sel_n), .DEPTH_SELECT_HIGH(1'b1), .DEPTH_SELECT_LOW_N(1'b0),
		.BYTE_LANE_WRITE_ENABLES_N(4'hF), .BYTE_WRITE_MASTER_ENABLE_N(1'b1),
		.ALL_BYTES_WRITE_N(gw_n), .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N),
		.SLEEP_REQUEST(SLEEP_REQUEST), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
		.RD_READY(RD_READY), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));
	task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] s);
		check_count++;
		if (e !== s)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic conclude();
		if (n_mismatch == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge SYS_CLK);
		{PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
		@(posedge SYS_CLK);
		PENABLE <= 1'b1;
		do @(posedge SYS_CLK); while (PREADY !== 1'b1);
		r = PRDATA;
		e = PSLVERR;
		{PSEL, PENABLE} <= 2'h0;
	endtask
	// Far side stalls during the burst, then takes every beat
	task automatic drain();
		RD_READY <= 1'b1;
		repeat (40)
		begin
			@(negedge SYS_CLK);
			if (exp_q.size() == 0)
				chk("extra beat", 36'h0, RD_VALID);
			else if (RD_VALID === 1'b1)
				chk("rd_data", exp_q.pop_front(), RD_DATA);
		end
		@(posedge SYS_CLK) RD_READY <= 1'b0;
		chk("beats left", 36'h0, 36'(exp_q.size()));
	endtask
	initial
	begin
		SYS_CLK = 1'b0;
		forever #4 SYS_CLK = ~SYS_CLK;
	end
	initial
	begin
		#200000;
		n_mismatch++;
		conclude();
	end
	initial
	begin
		logic [31:0] r;
		logic        e;
		logic [18:0] b;
		{RESETN, RD_READY, PSEL, PENABLE, PWRITE, PADDR, PWDATA, SLEEP_REQUEST} = '0;
		OUTPUT_ENABLE_N = 1'b1;
		dq_in = '0;
		void'($urandom(4));
		repeat (3) @(posedge SYS_CLK);
		RESETN <= 1'b1;
		apb(1'b0, `SBSA_REG_CTRL, 32'h0, r, e);
		chk("ctrl reset", `SBSA_CTRL_RST, r);
		apb(1'b0, 12'h00C, 32'h0, r, e);
		chk("unmapped err", 36'h1, e);
		for (int m = 0; m < 2; m++)
			for (int s = 0; s < 4; s++)
			begin
				apb(1'b1, `SBSA_REG_CTRL, {30'h0, m[0], 1'b1}, r, e);
				b = 19'($urandom) & 19'h7FFFC;
				for (int i = 0; i < 4; i++)
				begin
					mem[i] = 36'({$urandom, $urandom});
					cpu.start(b | 19'(i), i[0], 1'b1);
					dq_in <= mem[i];
					cpu.write1();
					dq_in <= ~mem[i];
				end
				cpu.start(b | 19'(s), s[0], 1'b1);
				cpu.burst();
				for (int i = 0; i < 4; i++)
					exp_q.push_back(mem[m ? (s ^ i) : ((s + i) & 3)]);
				drain();
			end
		cpu.start(19'h0, 1'b0, 1'b0);
		cpu.burst();
		drain();
		apb(1'b0, `SBSA_REG_COUNT, 32'h0, r, e);
		chk("beat count", 36'd32, r);
		cpu.start(19'h0, 1'b0, 1'b1);
		@(negedge SYS_CLK);
		OUTPUT_ENABLE_N = 1'b0;
		#1 chk("oe on", 36'h1, DQ_OE);
		SLEEP_REQUEST = 1'b1;
		#1 chk("oe sleep", 36'h0, DQ_OE);
		conclude();
	end
endmodule // tb_sbsa_top
`default_nettype wire
